// ### channel_level_select.sv
// one input channel: picks virtual or physical level into a flop
`timescale 1ns/10ps
`default_nettype none

module channel_level_select (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_select,
    input  wire logic        i_virtual_value,
    input  wire logic        i_terminal_level,
    output logic             o_level
);

    // ------------------------------------------------------------
    // level mux
    // ------------------------------------------------------------
    // value 0 means high level, so the stored bit is inverted
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_level <= virtual_io_pkg::LEVEL_RESET;
        end else if (i_select == virtual_io_pkg::SELECT_ACTIVE) begin
            o_level <= ~i_virtual_value;
        end else begin
            o_level <= i_terminal_level;
        end
    end

endmodule

`default_nettype wire

// ### host_model.sv
// host model: issues parameter reads and writes the way the serial link would
`timescale 1ns/10ps
`default_nettype none

module host_model (
    input  wire logic        i_clk_sys,
    output logic             o_param_write,
    output logic             o_param_read,
    output logic [15:0]      o_param_addr,
    output logic [15:0]      o_param_wdata
);
    initial begin
        o_param_write = 1'h0;
        o_param_read  = 1'h0;
        o_param_addr  = 16'h0000;
        o_param_wdata = 16'h0000;
    end

    // ------------------------------------------------------------
    // request cycles, launched off the falling edge
    // ------------------------------------------------------------
    task automatic access(input logic wr, input logic rd, input logic [15:0] a,
                          input logic [15:0] d);
        @(negedge i_clk_sys);
        o_param_write = wr;
        o_param_read  = rd;
        o_param_addr  = a;
        o_param_wdata = d;
    endtask

    // idle lines do not hold the last request, so address and data toggle
    task automatic idle(input int cycles);
        repeat (cycles) begin
            @(negedge i_clk_sys);
            o_param_write = 1'h0;
            o_param_read  = 1'h0;
            o_param_addr  = ~o_param_addr;
            o_param_wdata = ~o_param_wdata;
        end
    endtask
endmodule

`default_nettype wire

// ### tb_top.sv
// self-checking bench for the virtual terminal override block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic             clk = 1'h0;
    logic             rst = 1'h1;
    logic             param_write;
    logic             param_read;
    logic [15:0]      param_addr;
    logic [15:0]      param_wdata;
    logic [7:0][15:0] channel_select = '0;
    logic [7:0]       terminal_level = 8'hFF;
    logic             param_ack;
    logic             param_error;
    logic [15:0]      param_rdata;
    logic [7:0]       input_channel;
    logic [3:0]       output_level;
    logic [7:0]       vin = 8'h00;
    logic [3:0]       vout = 4'h0;
    logic [16:0]      exp_q[$];
    int               err_count = 0;
    int               samples_checked = 0;
    int               seed = 32'hAA1A;

    always #12.5 clk = ~clk;

    host_model u_host (.i_clk_sys(clk), .o_param_write(param_write), .o_param_read(param_read),
        .o_param_addr(param_addr), .o_param_wdata(param_wdata));

    virtual_io_override u_virtual_io_override (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_param_write(param_write), .i_param_read(param_read), .i_param_addr(param_addr),
        .i_param_wdata(param_wdata), .i_channel_select(channel_select),
        .i_terminal_level(terminal_level), .o_param_ack(param_ack), .o_param_error(param_error),
        .o_param_rdata(param_rdata), .o_input_channel(input_channel),
        .o_virtual_output_level(output_level));

    // ------------------------------------------------------------
    // reference model and comparisons
    // ------------------------------------------------------------
    function automatic int slot_of(input logic [15:0] a);
        if (a >= virtual_io_pkg::ADDR_VIRTUAL_INPUT_1_VALUE &&
            a <= virtual_io_pkg::ADDR_VIRTUAL_INPUT_8_VALUE) return int'(a - 16'h0D01);
        if (a >= virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_1_VALUE &&
            a <= virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_4_VALUE) return int'(a - 16'h0D03);
        return -1;
    endfunction

    task automatic report(input string what, input logic [16:0] exp, input logic [16:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic compare_answer(input logic [16:0] exp);
        report("parameter answer", exp, {param_error, param_rdata});
    endtask

    task automatic compare_levels();
        logic [7:0] e;
        for (int k = 0; k < 8; k++) begin
            e[k] = (channel_select[k] === virtual_io_pkg::SELECT_ACTIVE) ? ~vin[k]
                                                                       : terminal_level[k];
        end
        report("input channels", {9'h000, e}, {9'h000, input_channel});
        report("output levels", {13'h0000, ~vout}, {13'h0000, output_level});
    endtask

    // expectation is noted before the request goes out; a read sees the old value
    task automatic req(input logic wr, input logic rd, input logic [15:0] a,
                       input logic [15:0] d);
        int          s;
        logic        bad;
        logic [15:0] rv;
        s = slot_of(a);
        rv = 16'h0000;
        if (rd && s >= 0) rv = {15'h0000, (s < 8) ? vin[s] : vout[s - 8]};
        bad = (wr && (s < 0 || d > virtual_io_pkg::VALUE_MAX)) || (rd && s < 0);
        if (wr || rd) exp_q.push_back({bad, rv});
        if (wr && s >= 0 && d <= virtual_io_pkg::VALUE_MAX) begin
            if (s < 8) vin[s] = d[0];
            else vout[s - 8] = d[0];
        end
        u_host.access(wr, rd, a, d);
    endtask

    // two idle edges: the last write must already show at the levels
    task automatic settle();
        u_host.idle(2);
        report("pending answers", 17'h00000, 17'(exp_q.size()));
        compare_levels();
    endtask

    always @(negedge clk) begin
        if (!rst && param_ack === 1'h1) begin
            if (exp_q.size() == 0) report("stray answer", 17'h00000, 17'h1FFFF);
            else compare_answer(exp_q.pop_front());
        end
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        logic [15:0] a;
        logic [15:0] d;
        repeat (10) @(negedge clk);
        rst = 1'h0;
        settle();
        // defaults read back, with unmapped neighbours refused
        for (a = 16'h0D00; a <= 16'h0D10; a++) req(1'h0, 1'h1, a, 16'h0000);
        settle();
        for (int r = 0; r < 40; r++) begin
            for (int k = 0; k < 8; k++) begin
                channel_select[k] = ($random(seed) % 2) ? virtual_io_pkg::SELECT_ACTIVE
                                                        : 16'($random(seed));
            end
            terminal_level = 8'($random(seed));
            for (a = 16'h0D00; a <= 16'h0D10; a++) begin
                d = ($random(seed) % 8 == 0) ? 16'($random(seed)) : {15'h0000, 1'($random(seed))};
                req(1'($random(seed)), 1'($random(seed)), a, d);
                if ($random(seed) % 4 == 0) u_host.idle(1);
            end
            settle();
        end
        // a reset in mid-run must clear every stored value
        rst = 1'h1;
        u_host.idle(2);
        rst = 1'h0;
        vin = 8'h00;
        vout = 4'h0;
        settle();
        for (a = 16'h0D00; a <= 16'h0D10; a++) req(1'h0, 1'h1, a, 16'h0000);
        settle();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule

`default_nettype wire

// ### virtual_io_override.sv
// top of the virtual terminal override block: parameter store and levels
`timescale 1ns/10ps
`default_nettype none

module virtual_io_override (
    input  wire logic            i_clk_sys,
    input  wire logic            i_sys_rst,
    input  wire logic            i_param_write,
    input  wire logic            i_param_read,
    input  wire logic [15:0]     i_param_addr,
    input  wire logic [15:0]     i_param_wdata,
    input  wire logic [7:0][15:0] i_channel_select,
    input  wire logic [7:0]      i_terminal_level,
    output logic                 o_param_ack,
    output logic                 o_param_error,
    output logic [15:0]          o_param_rdata,
    output logic [7:0]           o_input_channel,
    output logic [3:0]           o_virtual_output_level
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [4:0] wr_slot;
    logic [4:0] rd_slot;
    logic       wr_in_range;
    logic       wr_take;
    logic [7:0] virtual_input;
    logic [3:0] virtual_output;
    logic [3:0] wr_index;

    assign wr_slot     = virtual_io_pkg::param_slot(i_param_addr);
    assign rd_slot     = virtual_io_pkg::param_slot(i_param_addr);
    assign wr_in_range = (i_param_wdata <= virtual_io_pkg::VALUE_MAX);
    assign wr_take     = i_param_write && wr_slot[4] && wr_in_range;
    assign wr_index    = wr_slot[3:0];

    // ------------------------------------------------------------
    // virtual input values
    // ------------------------------------------------------------
    // an out-of-range value is refused whole, the stored bit keeps its value
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            virtual_input <= {8{virtual_io_pkg::VALUE_RESET}};
        end else if (wr_take && !wr_index[3]) begin
            virtual_input[wr_index[2:0]] <= i_param_wdata[0];
        end
    end

    // ------------------------------------------------------------
    // virtual output values
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            virtual_output <= {4{virtual_io_pkg::VALUE_RESET}};
        end else if (wr_take && wr_index[3]) begin
            virtual_output[wr_index[1:0]] <= i_param_wdata[0];
        end
    end

    // ------------------------------------------------------------
    // output function levels
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_virtual_output_level <= {4{virtual_io_pkg::LEVEL_RESET}};
        end else begin
            o_virtual_output_level[0]   <= ~virtual_output[0];
            o_virtual_output_level[3:1] <= ~virtual_output[3:1];
        end
    end

    // ------------------------------------------------------------
    // answer to the parameter port
    // ------------------------------------------------------------
    // a read in the same cycle as a write returns the value before the write
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_param_ack   <= 1'h0;
            o_param_error <= 1'h0;
            o_param_rdata <= 16'h0000;
        end else begin
            o_param_ack   <= i_param_write || i_param_read;
            o_param_error <= (i_param_write && !(wr_slot[4] && wr_in_range))
                || (i_param_read && !rd_slot[4]);
            if (i_param_read && rd_slot[4]) begin
                o_param_rdata <= {15'h0000, rd_slot[3] ? virtual_output[rd_slot[1:0]]
                                                       : virtual_input[rd_slot[2:0]]};
            end else begin
                o_param_rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // input channels
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < 8; ch++) begin : g_channel
        channel_level_select u_select (
            .i_clk_sys        (i_clk_sys),
            .i_sys_rst        (i_sys_rst),
            .i_select         (i_channel_select[ch]),
            .i_virtual_value  (virtual_input[ch]),
            .i_terminal_level (i_terminal_level[ch]),
            .o_level          (o_input_channel[ch])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    logic wr_ok;
    assign wr_ok = i_param_write && (i_param_wdata <= virtual_io_pkg::VALUE_MAX);

    ch1_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_1_VALUE
        ##1 i_channel_select[0] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[0] == ~$past(i_param_wdata[0], 2))
        else $error("channel 1 did not follow its virtual value");

    ch2_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_2_VALUE
        ##1 i_channel_select[1] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[1] == ~$past(i_param_wdata[0], 2))
        else $error("channel 2 did not follow its virtual value");

    ch3_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_3_VALUE
        ##1 i_channel_select[2] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[2] == ~$past(i_param_wdata[0], 2))
        else $error("channel 3 did not follow its virtual value");

    ch4_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_4_VALUE
        ##1 i_channel_select[3] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[3] == ~$past(i_param_wdata[0], 2))
        else $error("channel 4 did not follow its virtual value");

    ch5_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_5_VALUE
        ##1 i_channel_select[4] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[4] == ~$past(i_param_wdata[0], 2))
        else $error("channel 5 did not follow its virtual value");

    ch6_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_6_VALUE
        ##1 i_channel_select[5] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[5] == ~$past(i_param_wdata[0], 2))
        else $error("channel 6 did not follow its virtual value");

    ch7_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_7_VALUE
        ##1 i_channel_select[6] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[6] == ~$past(i_param_wdata[0], 2))
        else $error("channel 7 did not follow its virtual value");

    ch8_virtual_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_8_VALUE
        ##1 i_channel_select[7] == virtual_io_pkg::SELECT_ACTIVE
        |=> o_input_channel[7] == ~$past(i_param_wdata[0], 2))
        else $error("channel 8 did not follow its virtual value");

    out1_level_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_1_VALUE
        |=> ##1 o_virtual_output_level[0] == ~$past(i_param_wdata[0], 2))
        else $error("output function 1 level wrong after write");

    out2_level_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_2_VALUE
        |=> ##1 o_virtual_output_level[1] == ~$past(i_param_wdata[0], 2))
        else $error("output function 2 level wrong after write");

    out3_level_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_3_VALUE
        |=> ##1 o_virtual_output_level[2] == ~$past(i_param_wdata[0], 2))
        else $error("output function 3 level wrong after write");

    out4_level_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_4_VALUE
        |=> ##1 o_virtual_output_level[3] == ~$past(i_param_wdata[0], 2))
        else $error("output function 4 level wrong after write");

    out4_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_4_VALUE
        ##1 (i_param_read && !i_param_write
             && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_4_VALUE)
        |=> o_param_rdata == $past(i_param_wdata, 2) && !o_param_error)
        else $error("output function 4 value did not read back");

    // ------------------------------------------------------------
    // parameter readback
    // ------------------------------------------------------------
    // a write in the read cycle does not matter: the read sees the older value
    in1_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_1_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_1_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 1 value did not read back");

    in2_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_2_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_2_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 2 value did not read back");

    in3_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_3_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_3_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 3 value did not read back");

    in4_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_4_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_4_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 4 value did not read back");

    in5_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_5_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_5_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 5 value did not read back");

    in6_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_6_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_6_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 6 value did not read back");

    in7_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_7_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_7_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 7 value did not read back");

    in8_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_8_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_8_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("input 8 value did not read back");

    out1_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_1_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_1_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("output 1 value did not read back");

    out2_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_2_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_2_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("output 2 value did not read back");

    out3_readback_a: assert property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_3_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_3_VALUE
        |=> o_param_rdata == $past(i_param_wdata, 2))
        else $error("output 3 value did not read back");

    value_refused_a: assert property (
        i_param_write && i_param_wdata > virtual_io_pkg::VALUE_MAX
        |=> o_param_error && o_param_ack && $stable(virtual_output)
            && $stable(virtual_input))
        else $error("out-of-range value was not refused");

    out_default_a: assert property (
        $past(i_sys_rst) |-> o_virtual_output_level == 4'hF && o_param_rdata == 16'h0000)
        else $error("output levels not at default after reset");

    for (genvar k = 0; k < 8; k++) begin : g_physical_check
        physical_path_a: assert property (
            i_channel_select[k] != virtual_io_pkg::SELECT_ACTIVE
            |=> o_input_channel[k] == $past(i_terminal_level[k]))
            else $error("unselected channel did not follow its terminal");
    end

    hold_steady_a: assert property (
        (i_channel_select[0] != virtual_io_pkg::SELECT_ACTIVE
         && $stable(i_terminal_level[0])) [*3]
        |-> $stable(o_input_channel[0]))
        else $error("unselected channel moved with steady terminal");

    ack_timing_a: assert property (
        (i_param_write || i_param_read) |=> o_param_ack)
        else $error("no answer one cycle after request");

    ack_only_a: assert property (
        !(i_param_write || i_param_read) |=> !o_param_ack && !o_param_error)
        else $error("answer without request");

    unmapped_a: assert property (
        i_param_read && !i_param_write
        && !rd_slot[4]
        |=> o_param_error && o_param_rdata == 16'h0000)
        else $error("unmapped read not flagged");

    unmapped_write_a: assert property (
        i_param_write && !wr_slot[4]
        |=> o_param_error && $stable(virtual_output) && $stable(virtual_input))
        else $error("unmapped write was not refused");

    rdata_idle_a: assert property (
        !(i_param_read && rd_slot[4]) |=> o_param_rdata == 16'h0000)
        else $error("read data not cleared without a mapped read");

    // the level flop lags the store by one edge, hence the extra cycle
    out1_hold_a: assert property (
        !(i_param_write && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_OUTPUT_1_VALUE)
        |=> ##1 $stable(o_virtual_output_level[0]))
        else $error("output function 1 level moved without a write");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    write_read_cv: cover property (i_param_write && i_param_read && wr_slot[4]);

    override_cv: cover property (
        (i_channel_select[3] == virtual_io_pkg::SELECT_ACTIVE) [*3]
        ##0 o_input_channel[3] != i_terminal_level[3]);

    refused_cv: cover property (
        i_param_write && i_param_wdata > virtual_io_pkg::VALUE_MAX);

    readback_cv: cover property (
        wr_ok && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_8_VALUE
        ##1 i_param_read && i_param_addr == virtual_io_pkg::ADDR_VIRTUAL_INPUT_8_VALUE);

    out_low_cv: cover property (o_virtual_output_level == 4'h0);

endmodule

`default_nettype wire

// ### virtual_io_pkg.sv
// constants and decode helpers for the virtual terminal override block
`default_nettype none

package virtual_io_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_INPUTS  = 8;
    localparam int unsigned NUM_OUTPUTS = 4;
    localparam int unsigned PARAM_WIDTH = 16;

    // ------------------------------------------------------------
    // parameter addresses: group in the high byte, index in the low
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_1_VALUE  = 16'h0D01;
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_2_VALUE  = 16'h0D02;
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_3_VALUE  = 16'h0D03;
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_4_VALUE  = 16'h0D04;
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_5_VALUE  = 16'h0D05;
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_6_VALUE  = 16'h0D06;
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_7_VALUE  = 16'h0D07;
    localparam logic [15:0] ADDR_VIRTUAL_INPUT_8_VALUE  = 16'h0D08;
    localparam logic [15:0] ADDR_VIRTUAL_OUTPUT_1_VALUE = 16'h0D0B;
    localparam logic [15:0] ADDR_VIRTUAL_OUTPUT_2_VALUE = 16'h0D0C;
    localparam logic [15:0] ADDR_VIRTUAL_OUTPUT_3_VALUE = 16'h0D0D;
    localparam logic [15:0] ADDR_VIRTUAL_OUTPUT_4_VALUE = 16'h0D0E;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [15:0] SELECT_ACTIVE = 16'h0001;
    localparam logic [15:0] VALUE_MAX     = 16'h0001;
    localparam logic        VALUE_RESET   = 1'h0;
    localparam logic        LEVEL_RESET   = 1'h1;

    // slot 0..7 virtual inputs, 8..11 virtual outputs; bit 4 marks a hit
    function automatic logic [4:0] param_slot(input logic [15:0] addr);
        logic [4:0] slot;
        slot = 5'h00;
        unique case (addr)
            ADDR_VIRTUAL_INPUT_1_VALUE:  slot = 5'h10;
            ADDR_VIRTUAL_INPUT_2_VALUE:  slot = 5'h11;
            ADDR_VIRTUAL_INPUT_3_VALUE:  slot = 5'h12;
            ADDR_VIRTUAL_INPUT_4_VALUE:  slot = 5'h13;
            ADDR_VIRTUAL_INPUT_5_VALUE:  slot = 5'h14;
            ADDR_VIRTUAL_INPUT_6_VALUE:  slot = 5'h15;
            ADDR_VIRTUAL_INPUT_7_VALUE:  slot = 5'h16;
            ADDR_VIRTUAL_INPUT_8_VALUE:  slot = 5'h17;
            ADDR_VIRTUAL_OUTPUT_1_VALUE: slot = 5'h18;
            ADDR_VIRTUAL_OUTPUT_2_VALUE: slot = 5'h19;
            ADDR_VIRTUAL_OUTPUT_3_VALUE: slot = 5'h1A;
            ADDR_VIRTUAL_OUTPUT_4_VALUE: slot = 5'h1B;
            default:                     slot = 5'h00;
        endcase
        return slot;
    endfunction

endpackage

`default_nettype wire
